// *** include/lfp_pkg.sv ***
// constants, register map and types of the line feed and paper end controller
package lfp_pkg;
	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned DEB_TIME_MS  = 5;
	localparam int unsigned DEB_CYCLES   = CLK_HZ / 1000 * DEB_TIME_MS;
	localparam int unsigned STEP_TIME_US = 2000;
	localparam int unsigned STEP_CYCLES  = CLK_HZ / 1_000_000 * STEP_TIME_US;
	localparam int unsigned DEB_CNT_W    = 18;
	localparam int unsigned DIV_W        = 20;

	localparam logic [5:0] STEPS_6LPI      = 6'h18;
	localparam logic [5:0] STEPS_8LPI      = 6'h12;
	localparam logic [1:0] LINES_AFTER_END = 2'h3;

	// byte addresses on the register bus
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_STAT = 5'h04;
	localparam logic [4:0] ADDR_IRQS = 5'h08;
	localparam logic [4:0] ADDR_MASK = 5'h0C;
	localparam logic [4:0] ADDR_STEP = 5'h10;

	// control register bits
	localparam int unsigned CB_LINE_DONE  = 0;
	localparam int unsigned CB_RET_HOME   = 1;
	localparam int unsigned CB_LPI8       = 2;
	localparam int unsigned CB_LINE_ACC   = 3;
	localparam int unsigned CB_PRINT_DONE = 4;
	localparam int unsigned CB_RX_ACTIVE  = 5;
	localparam int unsigned CB_GO_ONLINE  = 6;

	// interrupt status bits
	localparam int unsigned IB_FEED_DONE = 0;
	localparam int unsigned IB_HOME      = 1;
	localparam int unsigned IB_PAPER_END = 2;
	localparam int unsigned IB_OFFLINE   = 3;
	localparam int unsigned IRQ_W        = 4;

	// switch channels
	localparam int unsigned SW_SEL = 0;
	localparam int unsigned SW_LOW = 1;
	localparam int unsigned SW_OUT = 2;
	localparam int unsigned SW_N   = 3;

	localparam logic                 RST_ONLINE = 1'b1;
	localparam logic                 RST_LPI8   = 1'b0;
	localparam logic [IRQ_W-1:0]     RST_MASK   = 4'h0;

	typedef enum logic [1:0] {
		MOT_IDLE   = 2'b00,
		MOT_FEED   = 2'b01,
		MOT_RETURN = 2'b10
	} lfp_mot_t;

	// two-phase excitation: step index to phase pair, gray order
	function automatic logic [1:0] lfp_phase(input logic [1:0] idx);
		lfp_phase = {idx[1], idx[1] ^ idx[0]};
	endfunction : lfp_phase
endpackage : lfp_pkg

// *** include/lfp_sw_if.sv ***
// switch inputs between the controller and its debouncer
`timescale 1ns/10ps
interface lfp_sw_if;
	import lfp_pkg::*;
	logic [SW_N-1:0] raw;
	logic [SW_N-1:0] level;
	logic [SW_N-1:0] press;
	modport ctrl (output raw, input level, input press);
	modport deb  (input raw, output level, output press);
endinterface : lfp_sw_if

// *** verilog/lfp_debounce.sv ***
// synchroniser and debouncer for the select button and paper switches
`timescale 1ns/10ps
module lfp_debounce import lfp_pkg::*; #(
	parameter int unsigned P_CYCLES = DEB_CYCLES
) (
	input  wire logic i_ref_clk,
	input  wire logic i_rst,
	lfp_sw_if.deb     sw
);
	genvar g;
	generate
		for (g = 0; g < SW_N; g++) begin : g_ch
			logic                 s1_q, s2_q, lvl_q, lvl_d, pr_q, pr_d;
			logic [DEB_CNT_W-1:0] cnt_q, cnt_d;

			always_comb begin
				lvl_d = lvl_q;
				cnt_d = '0;
				pr_d  = 1'b0;
				// a change must hold for the full window before it counts
				if (s2_q != lvl_q) begin
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == DEB_CNT_W'(P_CYCLES - 1)) begin
						lvl_d = s2_q;
						cnt_d = '0;
						pr_d  = s2_q;
					end
				end
			end

			always_ff @(posedge i_ref_clk) begin
				if (i_rst) begin
					s1_q  <= 1'b0;
					s2_q  <= 1'b0;
					lvl_q <= 1'b0;
					cnt_q <= '0;
					pr_q  <= 1'b0;
				end else begin
					s1_q  <= sw.raw[g];
					s2_q  <= s1_q;
					lvl_q <= lvl_d;
					cnt_q <= cnt_d;
					pr_q  <= pr_d;
				end
			end

			assign sw.level[g] = lvl_q;
			assign sw.press[g] = pr_q;
		end
	endgenerate
endmodule : lfp_debounce

// *** verilog/lfp_ctrl.sv ***
// line feed, carriage return and paper end / select controller with Avalon-MM registers
`timescale 1ns/10ps
module lfp_ctrl import lfp_pkg::*; #(
	parameter int unsigned P_DEB_CYCLES  = DEB_CYCLES,
	parameter int unsigned P_STEP_CYCLES = STEP_CYCLES
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic [4:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_home_dark,
	input  wire logic        i_sel_button,
	input  wire logic        i_paper_low,
	input  wire logic        i_paper_out,
	output logic             o_space_phase_a,
	output logic             o_space_phase_b,
	output logic             o_feed_phase_a,
	output logic             o_feed_phase_b,
	output logic             o_feed_motor_overdrive_n,
	output logic             o_paper_end,
	output logic             o_select_lamp,
	output logic             o_paper_lamp,
	output logic             o_serial_ready_out,
	output logic             o_irq
);
	lfp_sw_if sw ();

	assign sw.raw[SW_SEL] = i_sel_button;
	assign sw.raw[SW_LOW] = i_paper_low;
	assign sw.raw[SW_OUT] = i_paper_out;

	lfp_debounce #(
		.P_CYCLES (P_DEB_CYCLES)
	) u_deb (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.sw        (sw)
	);

	// bus slave: one wait cycle, then the access completes
	logic              ack_q, ack_d;
	logic [31:0]       rdata_q, rdata_d;
	logic              wr_en;
	logic [31:0]       ctrl_wr;
	logic              lpi8_q, lpi8_d;
	logic              rx_act_q, rx_act_d;
	logic [DIV_W-1:0]  step_per_q, step_per_d;
	logic [IRQ_W-1:0]  mask_q, mask_d;
	logic [IRQ_W-1:0]  irqs_q, irqs_d, irq_set;

	// motion and paper state
	lfp_mot_t          mot_q, mot_d;
	logic [5:0]        steps_q, steps_d;
	logic [DIV_W-1:0]  div_q, div_d;
	logic [1:0]        sp_idx_q, sp_idx_d, fd_idx_q, fd_idx_d;
	logic [1:0]        sp_ph_q, sp_ph_d, fd_ph_q, fd_ph_d;
	logic              feed_pend_q, feed_pend_d;
	logic              online_q, online_d;
	logic              pend_off_q, pend_off_d;
	logic              pe_seen_q, pe_seen_d;
	logic [1:0]        pe_lines_q, pe_lines_d;
	logic              host_pe_q, host_pe_d;
	logic              plamp_q, plamp_d;
	logic              det_q, det;
	logic              home_s1_q, home_s2_q;
	logic              tick;

	// ack_q falls after the completing edge, so a request still held reads as a new one
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
	assign wr_en             = i_avs_write & ack_q;
	assign ctrl_wr           = (wr_en && i_avs_address == ADDR_CTRL) ? i_avs_writedata : 32'h0;

	always_comb begin
		ack_d      = (i_avs_read | i_avs_write) & ~ack_q;
		rdata_d    = rdata_q;
		lpi8_d     = lpi8_q;
		rx_act_d   = rx_act_q;
		step_per_d = step_per_q;
		mask_d     = mask_q;
		// read data is captured at the first edge so it stands while waitrequest is low
		if (i_avs_read && !ack_q) begin
			case (i_avs_address)
				ADDR_CTRL: rdata_d = {25'h0, 1'b0, rx_act_q, 2'h0, lpi8_q, 2'h0};
				ADDR_STAT: rdata_d = {22'h0, pe_lines_q, o_serial_ready_out, home_s2_q,
					online_q, plamp_q, host_pe_q, det_q, mot_q == MOT_RETURN,
					mot_q == MOT_FEED};
				ADDR_IRQS: rdata_d = {28'h0, irqs_q};
				ADDR_MASK: rdata_d = {28'h0, mask_q};
				ADDR_STEP: rdata_d = {12'h0, step_per_q};
				default:   rdata_d = 32'h0;
			endcase
		end
		if (wr_en) begin
			case (i_avs_address)
				ADDR_CTRL: begin
					lpi8_d   = i_avs_writedata[CB_LPI8];
					rx_act_d = i_avs_writedata[CB_RX_ACTIVE];
				end
				ADDR_MASK: mask_d = i_avs_writedata[IRQ_W-1:0];
				// a zero period would tick only once per wrap of the 20-bit counter and crawl the motor
				ADDR_STEP: step_per_d = (i_avs_writedata[DIV_W-1:0] == '0) ?
					DIV_W'(1) : i_avs_writedata[DIV_W-1:0];
				default: ;
			endcase
		end
		// a new event wins over a write-one clear in the same cycle
		irqs_d = irqs_q | irq_set;
		if (wr_en && i_avs_address == ADDR_IRQS)
			irqs_d = (irqs_q & ~i_avs_writedata[IRQ_W-1:0]) | irq_set;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			ack_q      <= 1'b0;
			rdata_q    <= 32'h0;
			lpi8_q     <= RST_LPI8;
			rx_act_q   <= 1'b0;
			step_per_q <= DIV_W'(P_STEP_CYCLES);
			mask_q     <= RST_MASK;
			irqs_q     <= '0;
		end else begin
			ack_q      <= ack_d;
			rdata_q    <= rdata_d;
			lpi8_q     <= lpi8_d;
			rx_act_q   <= rx_act_d;
			step_per_q <= step_per_d;
			mask_q     <= mask_d;
			irqs_q     <= irqs_d;
		end
	end

	// one period counter serves both motors, which never run together
	function automatic logic [DIV_W-1:0] next_div(input logic [DIV_W-1:0] cur,
		input logic at_end);
		next_div = at_end ? '0 : cur + DIV_W'(1);
	endfunction : next_div

	// either switch alone is enough to start the paper end sequence
	assign det  = sw.level[SW_LOW] | sw.level[SW_OUT];
	assign tick = (div_q == step_per_q - DIV_W'(1));

	always_comb begin
		mot_d       = mot_q;
		steps_d     = steps_q;
		div_d       = '0;
		sp_idx_d    = sp_idx_q;
		fd_idx_d    = fd_idx_q;
		feed_pend_d = feed_pend_q | ctrl_wr[CB_LINE_DONE];
		online_d    = online_q;
		pend_off_d  = pend_off_q;
		pe_seen_d   = pe_seen_q;
		pe_lines_d  = pe_lines_q;
		host_pe_d   = host_pe_q;
		plamp_d     = plamp_q;
		irq_set     = '0;
		case (mot_q)
			MOT_IDLE: begin
				// a queued line feed wins; a carriage return written in the same cycle is dropped, not queued
				if (feed_pend_d) begin
					mot_d       = MOT_FEED;
					feed_pend_d = 1'b0;
					// spacing written in the same word as the line strobe applies at once
					steps_d     = lpi8_d ? STEPS_8LPI : STEPS_6LPI;
				end else if (ctrl_wr[CB_RET_HOME]) begin
					mot_d = MOT_RETURN;
				end
			end
			MOT_FEED: begin
				div_d = next_div(div_q, tick);
				if (tick) begin
					fd_idx_d = fd_idx_q + 2'h1;
					steps_d  = steps_q - 6'h01;
					if (steps_q == 6'h01) begin
						mot_d                 = MOT_IDLE;
						irq_set[IB_FEED_DONE] = 1'b1;
					end
				end
			end
			MOT_RETURN: begin
				// stop as soon as the light path is broken, even mid period
				if (home_s2_q) begin
					mot_d            = MOT_IDLE;
					irq_set[IB_HOME] = 1'b1;
				end else begin
					div_d = next_div(div_q, tick);
					if (tick)
						sp_idx_d = sp_idx_q - 2'h1;
				end
			end
			default: mot_d = MOT_IDLE;
		endcase

		// paper end: latch once, then count the lines still accepted
		if (det && !det_q && !pe_seen_q) begin
			pe_seen_d              = 1'b1;
			pe_lines_d             = 2'h0;
			irq_set[IB_PAPER_END]  = 1'b1;
		end
		if (ctrl_wr[CB_LINE_ACC] && pe_seen_q && !host_pe_q) begin
			pe_lines_d = pe_lines_q + 2'h1;
			if (pe_lines_q == LINES_AFTER_END - 2'h1) begin
				host_pe_d           = 1'b1;
				online_d            = 1'b0;
				irq_set[IB_OFFLINE] = online_q;
			end
		end
		if (ctrl_wr[CB_PRINT_DONE]) begin
			if (host_pe_q)
				plamp_d = 1'b1;
			if (pend_off_q) begin
				online_d            = 1'b0;
				pend_off_d          = 1'b0;
				irq_set[IB_OFFLINE] = online_q;
			end
		end
		// the press only arms; going off-line waits until the pending print ends
		if (sw.press[SW_SEL] && online_q)
			pend_off_d = 1'b1;
		// back on line only with paper present
		if ((ctrl_wr[CB_GO_ONLINE] || (sw.press[SW_SEL] && !online_q)) && !det) begin
			online_d   = 1'b1;
			pe_seen_d  = 1'b0;
			pe_lines_d = 2'h0;
			host_pe_d  = 1'b0;
			plamp_d    = 1'b0;
			pend_off_d = 1'b0;
		end
		sp_ph_d = lfp_phase(sp_idx_d);
		fd_ph_d = lfp_phase(fd_idx_d);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			mot_q       <= MOT_IDLE;
			steps_q     <= 6'h00;
			div_q       <= '0;
			sp_idx_q    <= 2'h0;
			fd_idx_q    <= 2'h0;
			sp_ph_q     <= 2'h0;
			fd_ph_q     <= 2'h0;
			feed_pend_q <= 1'b0;
			online_q    <= RST_ONLINE;
			pend_off_q  <= 1'b0;
			pe_seen_q   <= 1'b0;
			pe_lines_q  <= 2'h0;
			host_pe_q   <= 1'b0;
			plamp_q     <= 1'b0;
			det_q       <= 1'b0;
			home_s1_q   <= 1'b0;
			home_s2_q   <= 1'b0;
		end else begin
			mot_q       <= mot_d;
			steps_q     <= steps_d;
			div_q       <= div_d;
			sp_idx_q    <= sp_idx_d;
			fd_idx_q    <= fd_idx_d;
			sp_ph_q     <= sp_ph_d;
			fd_ph_q     <= fd_ph_d;
			feed_pend_q <= feed_pend_d;
			online_q    <= online_d;
			pend_off_q  <= pend_off_d;
			pe_seen_q   <= pe_seen_d;
			pe_lines_q  <= pe_lines_d;
			host_pe_q   <= host_pe_d;
			plamp_q     <= plamp_d;
			det_q       <= det;
			home_s1_q   <= i_home_dark;
			home_s2_q   <= home_s1_q;
		end
	end

	assign o_avs_readdata           = rdata_q;
	assign o_space_phase_a          = sp_ph_q[1];
	assign o_space_phase_b          = sp_ph_q[0];
	assign o_feed_phase_a           = fd_ph_q[1];
	assign o_feed_phase_b           = fd_ph_q[0];
	// low drives full torque; high leaves the motor on holding power
	assign o_feed_motor_overdrive_n = (mot_q != MOT_FEED);
	assign o_paper_end              = host_pe_q;
	assign o_select_lamp            = online_q;
	assign o_paper_lamp             = plamp_q;
	// after paper end the port stays ready only while a line is still being taken in
	assign o_serial_ready_out       = online_q & ~host_pe_q & (~pe_seen_q | rx_act_q);
	// level output; software removes the cause by writing ones to the status
	assign o_irq                    = |(irqs_q & mask_q);
endmodule : lfp_ctrl

// *** tb/lfp_mech_model.sv ***
// motor and home sensor model of the printer mechanism
`timescale 1ns/10ps
module lfp_mech_model #(
	parameter int P_START = 3
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_space_a,
	input  wire logic       i_space_b,
	input  wire logic       i_feed_a,
	input  wire logic       i_feed_b,
	output logic            o_home_dark,
	output logic      [7:0] o_feed_steps,
	output logic      [7:0] o_back_steps
);
	logic [1:0] sp_q;
	logic [1:0] fp_q;
	logic [1:0] dlt;
	int         pos;
	// carriage position in steps; the sensor goes dark at or left of home
	// state moves by non-blocking assignment so the sensor never races the sampling edge
	always @(posedge i_ref_clk) begin
		dlt = {i_space_a, i_space_a ^ i_space_b} - {sp_q[1], sp_q[1] ^ sp_q[0]};
		if (i_rst) begin
			pos          <= P_START;
			o_feed_steps <= 8'h00;
			o_back_steps <= 8'h00;
		end else begin
			if (dlt == 2'h1)
				pos <= pos + 1;
			if (dlt == 2'h3) begin
				pos          <= pos - 1;
				o_back_steps <= o_back_steps + 8'h01;
			end
			if ({i_feed_a, i_feed_b} != fp_q)
				o_feed_steps <= o_feed_steps + 8'h01;
		end
		sp_q <= {i_space_a, i_space_b};
		fp_q <= {i_feed_a, i_feed_b};
	end
	assign o_home_dark = (pos <= 0);
endmodule : lfp_mech_model

// *** tb/lfp_ctrl_props.sv ***
// port assertions of the line feed and paper end controller
`timescale 1ns/10ps
module lfp_ctrl_props (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest,
	input wire logic i_home_dark,
	input wire logic o_space_phase_a,
	input wire logic o_space_phase_b,
	input wire logic o_feed_phase_a,
	input wire logic o_feed_phase_b,
	input wire logic o_feed_motor_overdrive_n,
	input wire logic o_paper_end,
	input wire logic o_select_lamp,
	input wire logic o_paper_lamp,
	input wire logic o_serial_ready_out
);
	wire logic [1:0] sp = {o_space_phase_a, o_space_phase_b};
	wire logic [1:0] fp = {o_feed_phase_a, o_feed_phase_b};
	wire logic       od = o_feed_motor_overdrive_n;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	sequence s_req_wait;
		(i_avs_read || i_avs_write) && o_avs_waitrequest;
	endsequence
	// sync plus stop plus phase register all fit inside six cycles
	sequence s_home_seen;
		i_home_dark [*6];
	endsequence
	a_bus_one_wait: assert property (s_req_wait |=> !o_avs_waitrequest)
		else $error("more than one wait cycle");
	a_idle_no_wait: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
		else $error("wait without request");
	a_feed_gray: assert property ($changed(fp) |-> (fp ^ $past(fp)) inside {2'b01, 2'b10})
		else $error("feed phase jump");
	a_space_gray: assert property ($changed(sp) |-> (sp ^ $past(sp)) inside {2'b01, 2'b10})
		else $error("space phase jump");
	a_feed_hold: assert property (od && $past(od) && $past(od, 2) |-> $stable(fp))
		else $error("feed step on holding power");
	a_one_motor: assert property ($changed(fp) |-> $stable(sp))
		else $error("both motors stepping");
	a_home_stop: assert property (s_home_seen |=> $stable(sp))
		else $error("space motor past home");
	a_end_busy: assert property (o_paper_end |-> !o_serial_ready_out)
		else $error("ready at paper end");
	a_offline_busy: assert property (!o_select_lamp |-> !o_serial_ready_out)
		else $error("ready while off-line");
	a_lamp_cause: assert property ($rose(o_paper_lamp) |-> o_paper_end)
		else $error("paper lamp without paper end");
endmodule : lfp_ctrl_props

bind lfp_ctrl lfp_ctrl_props u_props (.*);

// *** tb/lfp_ctrl_test.sv ***
// self-checking bench of the line feed and paper end controller
`timescale 1ns/10ps
module lfp_ctrl_test import lfp_pkg::*;;
	localparam int unsigned STEP = 5;
	logic        clk, rst, rd, wr, wrq, sel, plow, pout, home;
	logic        sa, sb, fa, fb, odn, pend, slamp, plamp, srdy, irq;
	logic [4:0]  addr;
	logic [31:0] wdata, rdata, r;
	logic [7:0]  fst, bst;
	int          failures, tests_run;
	lfp_ctrl #(.P_DEB_CYCLES(4), .P_STEP_CYCLES(STEP)) dut (.i_ref_clk(clk), .i_rst(rst),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wrq), .i_home_dark(home),
		.i_sel_button(sel), .i_paper_low(plow), .i_paper_out(pout), .o_space_phase_a(sa),
		.o_space_phase_b(sb), .o_feed_phase_a(fa), .o_feed_phase_b(fb),
		.o_feed_motor_overdrive_n(odn), .o_paper_end(pend), .o_select_lamp(slamp),
		.o_paper_lamp(plamp), .o_serial_ready_out(srdy), .o_irq(irq));
	lfp_mech_model mech (.i_ref_clk(clk), .i_rst(rst), .i_space_a(sa), .i_space_b(sb),
		.i_feed_a(fa), .i_feed_b(fb), .o_home_dark(home), .o_feed_steps(fst),
		.o_back_steps(bst));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		rd <= !we;
		wr <= we;
		addr <= a;
		wdata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wrq !== 1'b0 && n < 50);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 50) begin
			chk(32'h0, 32'h1);
			tally_and_finish;
		end
	endtask : bus
	// waits on overdrive (0), irq (1)
	task automatic wait_sig(input int which, input logic v);
		int n;
		for (n = 0; n < 2000 && ((which == 0) ? odn : irq) !== v; n++)
			@(posedge clk);
		if (n >= 2000) begin
			chk(32'h0, 32'h1);
			tally_and_finish;
		end
	endtask : wait_sig
	task automatic t_reset;
		chk({odn, pend, slamp, plamp, srdy, irq, fa, fb, sa, sb}, 32'h2A0);
		bus(1'b0, ADDR_STEP, 32'h0);
		chk(r, STEP);
		bus(1'b0, 5'h14, 32'h0);
		chk(r, 32'h0);
		bus(1'b0, ADDR_MASK, 32'h0);
		chk(r, {28'h0, RST_MASK});
	endtask : t_reset
	task automatic t_feed(input logic l8, input logic [7:0] exp);
		logic [7:0] f0;
		f0 = fst;
		bus(1'b1, ADDR_MASK, 32'h1);
		bus(1'b1, ADDR_CTRL, {29'h0, l8, 2'b01});
		wait_sig(0, 1'b0);
		wait_sig(0, 1'b1);
		repeat (2) @(posedge clk);
		chk({24'h0, fst - f0}, {24'h0, exp});
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, ADDR_IRQS, 32'h1);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
	endtask : t_feed
	task automatic t_home;
		bus(1'b1, ADDR_MASK, 32'h2);
		bus(1'b1, ADDR_CTRL, 32'h2);
		wait_sig(1, 1'b1);
		repeat (8) @(posedge clk);
		chk({24'h0, bst}, 32'h3);
		bus(1'b1, ADDR_IRQS, 32'h2);
	endtask : t_home
	task automatic t_paper(input logic use_out);
		{pout, plow} <= use_out ? 2'b10 : 2'b01;
		@(posedge clk);
		{pout, plow} <= 2'b00;
		repeat (20) @(posedge clk);
		chk({31'h0, srdy}, 32'h1);
		{pout, plow} <= use_out ? 2'b10 : 2'b01;
		repeat (20) @(posedge clk);
		chk({31'h0, srdy}, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h20);
		@(posedge clk);
		chk({31'h0, srdy}, 32'h1);
		repeat (2) bus(1'b1, ADDR_CTRL, 32'h8);
		@(posedge clk);
		chk({31'h0, pend}, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h8);
		@(posedge clk);
		chk({pend, slamp, srdy, plamp}, 32'h8);
		bus(1'b0, ADDR_STAT, 32'h0);
		chk(r, 32'h34C);
		bus(1'b1, ADDR_CTRL, 32'h10);
		@(posedge clk);
		chk({31'h0, plamp}, 32'h1);
		{pout, plow} <= 2'b00;
		repeat (20) @(posedge clk);
		bus(1'b1, ADDR_CTRL, 32'h40);
		@(posedge clk);
		chk({pend, slamp, srdy, plamp}, 32'h6);
	endtask : t_paper
	task automatic t_select;
		sel <= 1'b1;
		repeat (20) @(posedge clk);
		sel <= 1'b0;
		repeat (20) @(posedge clk);
		chk({31'h0, slamp}, 32'h1);
		bus(1'b1, ADDR_CTRL, 32'h10);
		@(posedge clk);
		chk({slamp, srdy}, 32'h0);
	endtask : t_select
	initial begin
		{rst, rd, wr, sel, plow, pout} = 6'h20;
		addr = 5'h00;
		wdata = 32'h0;
		failures = 0;
		tests_run = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_feed(1'b0, 8'h18);
		t_feed(1'b1, 8'h12);
		t_home;
		t_paper(1'b0);
		t_paper(1'b1);
		t_select;
		tally_and_finish;
	end
endmodule : lfp_ctrl_test
